// ==== touch_controller_host_port.sv ====
// Purpose: serial register port, result store and pen flag of a touch controller
// Assumes: sclk, chip select, data and x plate level are pins, synchronised here
// Notes:   header bit 7 set means read, bits 6..0 the start address
//
// Notes on behaviour
// R1 - chip select falling starts a header
// R2 - clock modes 0 and 3 both work
// R3 - host sends header then data, MSB first
// R4 - write commits on eighth rising clock
// R5 - chip select high ignores clock, data
// R6 - output stays off during writes
// R7 - burst advances address; read-only writes dropped
// R8 - address after 24H wraps to 00H
// R9 - read data changes on falling clock
// R10 - output off when deselected and header
// R11 - write-only locations read as 00H
// R12 - host sends system reset after power-up
// R13 - system reset aborts, clears, enters standby
// R14 - host restarts with new header after reset
// R15 - pen detect grounds y, pulls x up
// R16 - busy sequence turns pen flag into busy
// R17 - sleep holds pen flag high or open
// R18 - host may mask flag while busy
// R19 - program 1010 stores dual-touch results
// R20 - 12-bit results split high/low addresses
// R21 - status D5, D4 flag weak pressure
// R22 - status D3 gives y difference sign
// R23 - status D2 marks dual touch
// R24 - write to 00H D0 resets, unstored
// R25 - doze 01 high, 10 open, panel open
// R26 - header holds read flag and address
`timescale 1ns/10ps
`default_nettype none
module touch_controller_host_port
  import touch_port_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            sclkPin,
  input  wire logic            chip_select_low,
  input  wire logic            serial_in,
  output var  logic            serial_out,
  output var  logic            serialOutEn,
  input  wire logic            xPlusLevel,
  input  wire measure_result_t measureResult,
  input  wire logic            resultStrobe,
  input  wire logic            sequenceBusy,
  input  wire logic            sequenceValid,
  output var  logic            pen_touch_flag_n,
  output var  logic            penFlagEn,
  output var  logic            yMinusGroundEn,
  output var  logic            xPlusPullupEn,
  output var  logic [3:0]      measure_program_sel,
  output var  logic [2:0]      intervalSelect,
  output var  logic [1:0]      doze_select,
  output var  logic [2:0]      filterSelect,
  output var  logic            abortSequence
);

  logic [3:0]      pinSync;
  logic            sclkSync;
  logic            csnSync;
  logic            sdiSync;
  logic            xPlusSync;
  logic            sclkLast;
  logic            csnLast;
  logic            sclkRise;
  logic            sclkFall;
  logic            csnFall;
  port_state_t     state;
  logic [2:0]      bitCount;
  logic [7:0]      rxShift;
  logic [7:0]      rxByte;
  logic            byteDone;
  logic [6:0]      addr;
  logic [6:0]      nextAddr;
  logic [7:0]      txShift;
  logic            writeCommit;
  logic            doSoftReset;
  logic [7:0]      cfgRegs [0:REG_COUNT-1];
  measure_result_t stored;

  pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk    (clk),
    .reset_n(reset_n),
    .pinIn  ({sclkPin, chip_select_low, serial_in, xPlusLevel}),
    .syncOut(pinSync)
  );

  assign sclkSync  = pinSync[3];
  assign csnSync   = pinSync[2];
  assign sdiSync   = pinSync[1];
  assign xPlusSync = pinSync[0];

  // edge finders on synchronised pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkLast <= 1'b0;
      csnLast  <= 1'b0;
    end else begin
      sclkLast <= sclkSync;
      csnLast  <= csnSync;
    end
  end

  // R2 mode 0 and 3: sample on rising, shift on falling
  assign sclkRise = sclkSync & ~sclkLast;
  assign sclkFall = ~sclkSync & sclkLast;
  // R1 start of transaction
  assign csnFall  = ~csnSync & csnLast;
  assign rxByte   = {rxShift[6:0], sdiSync};
  assign byteDone = sclkRise && (bitCount == LAST_BIT);
  // R8 wrap after last address
  assign nextAddr = (addr >= ADDR_LAST) ? ADDR_RESET : 7'(addr + 7'h01);
  // R4 commit on the eighth rising edge
  assign writeCommit = byteDone && (state == PORT_WRITE);
  // R24 reset command, no storage
  assign doSoftReset = writeCommit && (addr == ADDR_RESET) && rxByte[SOFT_RESET_BIT];

  function automatic logic isWritable(input logic [6:0] a);
    return ((a >= ADDR_SETUP) && (a <= ADDR_CFG_LAST)) ||
           ((a >= ADDR_TRIM_FIRST) && (a <= ADDR_TRIM_LAST));
  endfunction

  function automatic logic [7:0] readByte(input logic [6:0] a);
    logic [7:0] value;
    value = READ_EMPTY;
    // R21 R22 R23 status layout
    if (a == ADDR_STATUS) begin
      value = {1'b0, stored.touching, stored.weakPressTwoPoint, stored.weakPressOnePoint,
               stored.slopeSignFlag, stored.dualSeen, sequenceValid, sequenceBusy};
    // R20 high eight bits (six for pressure x), then low four in D7-D4
    end else if (a == ADDR_CX_HIGH) begin
      value = stored.centerX[11:4];
    end else if (a == ADDR_CX_LOW) begin
      value = {stored.centerX[3:0], 4'h0};
    end else if (a == ADDR_CY_HIGH) begin
      value = stored.centerY[11:4];
    end else if (a == ADDR_CY_LOW) begin
      value = {stored.centerY[3:0], 4'h0};
    end else if (a == ADDR_SX_HIGH) begin
      value = stored.spreadX[11:4];
    end else if (a == ADDR_SX_LOW) begin
      value = {stored.spreadX[3:0], 4'h0};
    end else if (a == ADDR_SY_HIGH) begin
      value = stored.spreadY[11:4];
    end else if (a == ADDR_SY_LOW) begin
      value = {stored.spreadY[3:0], 4'h0};
    end else if (a == ADDR_PX_HIGH) begin
      value = {2'b00, stored.pressureX[9:4]};
    end else if (a == ADDR_PX_LOW) begin
      value = {stored.pressureX[3:0], 4'h0};
    end else if (a == ADDR_DIST_SUM) begin
      value = stored.distanceSum;
    end else if (isWritable(a)) begin
      value = cfgRegs[a[5:0]];
    end else begin
      // R11 write-only and reserved read empty
      value = READ_EMPTY;
    end
    return value;
  endfunction

  // receive side state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= PORT_IDLE;
      bitCount <= 3'h0;
      rxShift  <= 8'h00;
      addr     <= ADDR_RESET;
    // R5 deselected: ignore clock and data
    end else if (csnSync) begin
      state    <= PORT_IDLE;
      bitCount <= 3'h0;
    end else if (csnFall) begin
      state    <= PORT_HEADER;
      bitCount <= 3'h0;
    end else if (sclkRise) begin
      rxShift  <= rxByte;
      bitCount <= 3'(bitCount + 3'h1);
      if (byteDone) begin
        case (state)
          PORT_HEADER: begin
            // R26 read flag and start address
            addr  <= rxByte[6:0];
            state <= rxByte[HDR_READ_BIT] ? PORT_READ : PORT_WRITE;
          end
          PORT_WRITE: begin
            // R13 reset ends the burst
            if (doSoftReset) begin
              state <= PORT_HALTED;
              addr  <= ADDR_RESET;
            end else begin
              // R7 burst advance
              addr <= nextAddr;
            end
          end
          PORT_READ: begin
            addr <= nextAddr;
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

  // transmit side
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txShift     <= 8'h00;
      serial_out  <= 1'b0;
      serialOutEn <= 1'b0;
    // R10 off while deselected
    end else if (csnSync) begin
      serial_out  <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (byteDone && (state == PORT_HEADER) && rxByte[HDR_READ_BIT]) begin
      txShift <= readByte(rxByte[6:0]);
    end else if (byteDone && (state == PORT_READ)) begin
      // R7 next byte of a read burst
      txShift <= readByte(nextAddr);
    // R9 R6 drive only in read data phase
    end else if (sclkFall && (state == PORT_READ)) begin
      serial_out  <= txShift[7];
      txShift     <= {txShift[6:0], 1'b0};
      serialOutEn <= 1'b1;
    end
  end

  // setting registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        cfgRegs[i] <= CFG_RESET;
      end
    // R13 clear settings
    end else if (doSoftReset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        cfgRegs[i] <= CFG_RESET;
      end
    // R7 read-only targets silently dropped
    end else if (writeCommit && isWritable(addr)) begin
      cfgRegs[addr[5:0]] <= rxByte;
    end
  end

  // configuration outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      measure_program_sel <= 4'h0;
      intervalSelect      <= 3'h0;
      doze_select         <= 2'b00;
      filterSelect        <= 3'h0;
      abortSequence       <= 1'b0;
    end else begin
      measure_program_sel <= cfgRegs[ADDR_SEQUENCE[5:0]][PROGRAM_LSB +: 4];
      intervalSelect      <= cfgRegs[ADDR_SEQUENCE[5:0]][INTERVAL_LSB +: 3];
      doze_select         <= cfgRegs[ADDR_SETUP[5:0]][DOZE_LSB +: 2];
      filterSelect        <= cfgRegs[ADDR_SETUP[5:0]][FILTER_LSB +: 3];
      // R13 abort running sequence
      abortSequence       <= doSoftReset;
    end
  end

  // measurement result store
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stored <= RESULT_RESET;
    // R13 clear measurement data
    end else if (doSoftReset) begin
      stored <= RESULT_RESET;
    // R19 dual-touch program stores results
    end else if (resultStrobe && (measure_program_sel == PROG_DUAL)) begin
      stored <= measureResult;
    end
  end

  // pen flag and panel drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pen_touch_flag_n <= 1'b1;
      penFlagEn        <= 1'b1;
      yMinusGroundEn   <= 1'b0;
      xPlusPullupEn    <= 1'b0;
    // R17 R25 sleep: pen off, panel open
    end else if ((doze_select == DOZE_HIGH) || (doze_select == DOZE_OPEN)) begin
      pen_touch_flag_n <= 1'b1;
      penFlagEn        <= (doze_select == DOZE_HIGH);
      yMinusGroundEn   <= 1'b0;
      xPlusPullupEn    <= 1'b0;
    // R16 busy indication
    end else if (sequenceBusy) begin
      pen_touch_flag_n <= 1'b0;
      penFlagEn        <= 1'b1;
      yMinusGroundEn   <= 1'b0;
      xPlusPullupEn    <= 1'b0;
    end else begin
      // R15 pen detect from x plate node
      pen_touch_flag_n <= xPlusSync;
      penFlagEn        <= 1'b1;
      yMinusGroundEn   <= 1'b1;
      xPlusPullupEn    <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== touch_port_pkg.sv ====
// Purpose: shared constants and types of the touch controller host port
// Assumes: one 40 MHz clock; serial pins sampled by that clock
// Notes:   register addresses are byte indices on the serial port
package touch_port_pkg;

  localparam logic [6:0] ADDR_RESET      = 7'h00;
  localparam logic [6:0] ADDR_SETUP      = 7'h01;
  localparam logic [6:0] ADDR_SEQUENCE   = 7'h02;
  localparam logic [6:0] ADDR_CFG_LAST   = 7'h0C;
  localparam logic [6:0] ADDR_STATUS     = 7'h10;
  localparam logic [6:0] ADDR_CX_HIGH    = 7'h11;
  localparam logic [6:0] ADDR_CX_LOW     = 7'h12;
  localparam logic [6:0] ADDR_CY_HIGH    = 7'h13;
  localparam logic [6:0] ADDR_CY_LOW     = 7'h14;
  localparam logic [6:0] ADDR_SX_HIGH    = 7'h15;
  localparam logic [6:0] ADDR_SX_LOW     = 7'h16;
  localparam logic [6:0] ADDR_SY_HIGH    = 7'h17;
  localparam logic [6:0] ADDR_SY_LOW     = 7'h18;
  localparam logic [6:0] ADDR_PX_HIGH    = 7'h19;
  localparam logic [6:0] ADDR_PX_LOW     = 7'h1A;
  localparam logic [6:0] ADDR_TRIM_FIRST = 7'h20;
  localparam logic [6:0] ADDR_TRIM_LAST  = 7'h23;
  localparam logic [6:0] ADDR_DIST_SUM   = 7'h24;
  localparam logic [6:0] ADDR_LAST       = 7'h24;
  localparam int         REG_COUNT       = 37;

  localparam int         HDR_READ_BIT    = 7;
  localparam int         SOFT_RESET_BIT  = 0;
  localparam int         DOZE_LSB        = 4;
  localparam int         FILTER_LSB      = 0;
  localparam int         PROGRAM_LSB     = 4;
  localparam int         INTERVAL_LSB    = 0;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] READ_EMPTY      = 8'h00;
  localparam logic [2:0] LAST_BIT        = 3'h7;

  localparam logic [3:0] PROG_DUAL       = 4'b1010;
  localparam logic [1:0] DOZE_HIGH       = 2'b01;
  localparam logic [1:0] DOZE_OPEN       = 2'b10;

  typedef struct packed {
    logic [11:0] centerX;
    logic [11:0] centerY;
    logic [11:0] spreadX;
    logic [11:0] spreadY;
    logic        touching;
    logic        weakPressTwoPoint;
    logic        weakPressOnePoint;
    logic        slopeSignFlag;
    logic        dualSeen;
    logic [9:0]  pressureX;
    logic [7:0]  distanceSum;
  } measure_result_t;

  localparam measure_result_t RESULT_RESET = '0;

  typedef enum logic [2:0] {
    PORT_IDLE,
    PORT_HEADER,
    PORT_WRITE,
    PORT_READ,
    PORT_HALTED
  } port_state_t;

endpackage

// ==== pin_sync.sv ====
// Purpose: two-flop synchroniser for pins entering the clk domain
// Assumes: inputs are slow levels compared with clk
// Notes:   only the second stage is visible outside
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stageOne[i] <= 1'b0;
          syncOut[i]  <= 1'b0;
        end else begin
          stageOne[i] <= pinIn[i];
          syncOut[i]  <= stageOne[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== touch_port_checker_sva.sv ====
// Purpose: port assertions of the touch host port
// Assumes: pins as seen at the top module
// Notes:   bound below
`timescale 1ns/10ps
`default_nettype none
module touch_port_checker (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sclkPin,
  input wire logic       chip_select_low,
  input wire logic       serial_out,
  input wire logic       serialOutEn,
  input wire logic       xPlusLevel,
  input wire logic       sequenceBusy,
  input wire logic       pen_touch_flag_n,
  input wire logic       penFlagEn,
  input wire logic       yMinusGroundEn,
  input wire logic       xPlusPullupEn,
  input wire logic [3:0] measure_program_sel,
  input wire logic [1:0] doze_select,
  input wire logic       abortSequence
);
  logic [7:0] lowCount;
  logic       normal;
  assign normal = doze_select == 2'b00;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles since chip select fell
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) lowCount <= 8'h00;
    else if (chip_select_low) lowCount <= 8'h00;
    else if (lowCount != 8'hFF) lowCount <= lowCount + 8'h01;
  end
  desel_off_a: assert property (chip_select_low [*6] |-> !serialOutEn)
    else $error("output on while deselected");
  header_quiet_a: assert property ($rose(serialOutEn) |-> lowCount > 8'h3C)
    else $error("output on during header");
  fall_edge_a: assert property (serialOutEn && $changed(serial_out) |-> !sclkPin)
    else $error("output moved off falling clock");
  abort_clear_a: assert property (abortSequence |-> ##[0:1] (measure_program_sel == 4'h0 && normal))
    else $error("reset left settings");
  pen_level_a: assert property ((normal && !sequenceBusy && $stable(xPlusLevel)) [*5]
    |-> pen_touch_flag_n == xPlusLevel)
    else $error("pen flag not plate level");
  busy_flag_a: assert property ((normal && sequenceBusy) [*2] |-> !pen_touch_flag_n)
    else $error("busy not shown");
  doze_high_a: assert property ((doze_select == 2'b01) [*2]
    |-> pen_touch_flag_n && penFlagEn && !yMinusGroundEn && !xPlusPullupEn)
    else $error("sleep one wrong");
  doze_open_a: assert property ((doze_select == 2'b10) [*2] |-> !penFlagEn && !yMinusGroundEn)
    else $error("sleep two wrong");
  cover property ($rose(serialOutEn));
  cover property (abortSequence);
  cover property (normal && sequenceBusy ##1 !pen_touch_flag_n);
endmodule
bind touch_controller_host_port touch_port_checker chk_u (.clk(clk), .reset_n(reset_n),
  .sclkPin(sclkPin), .chip_select_low(chip_select_low), .serial_out(serial_out),
  .serialOutEn(serialOutEn), .xPlusLevel(xPlusLevel), .sequenceBusy(sequenceBusy),
  .pen_touch_flag_n(pen_touch_flag_n), .penFlagEn(penFlagEn),
  .yMinusGroundEn(yMinusGroundEn), .xPlusPullupEn(xPlusPullupEn),
  .measure_program_sel(measure_program_sel), .doze_select(doze_select),
  .abortSequence(abortSequence));
`default_nettype wire

// ==== spi_host_model.sv ====
// Purpose: host side of the serial register link
// Assumes: sclk half period is four clk
// Notes:   released data line inverts
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input  wire logic clk,
  input  wire logic serial_out,
  input  wire logic serialOutEn,
  output var  logic sclkPin,
  output var  logic chip_select_low,
  output var  logic serial_in
);
  logic cpol = 1'b0;
  initial begin
    sclkPin = 1'b0;
    chip_select_low = 1'b1;
    serial_in = 1'b0;
  end
  task automatic half;
    repeat (4) @(posedge clk);
  endtask
  task automatic start_frame(input logic m3);
    cpol = m3;
    sclkPin <= m3;
    half;
    chip_select_low <= 1'b0;
    half;
  endtask
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (cpol) sclkPin <= 1'b0;
      serial_in <= tx[i];
      half;
      sclkPin <= 1'b1;
      rx[i] = serialOutEn ? serial_out : 1'bx;
      half;
      if (!cpol) sclkPin <= 1'b0;
    end
  endtask
  task automatic end_frame;
    half;
    chip_select_low <= 1'b1;
    serial_in <= ~serial_in;
    repeat (6) @(posedge clk);
  endtask
  task automatic noise;
    repeat (16) begin
      sclkPin <= ~sclkPin;
      serial_in <= ~serial_in;
      half;
    end
  endtask
endmodule
`default_nettype wire

// ==== touch_controller_host_port_test.sv ====
// Purpose: self-checking bench of the touch host port
// Assumes: host model drives the serial pins
// Notes:   checker is bound from its own file
`timescale 1ns/10ps
`default_nettype none
module touch_controller_host_port_test
  import touch_port_pkg::*;
;
  logic            clk = 1'b0;
  logic            reset_n, xPlusLevel, resultStrobe, sequenceBusy, sequenceValid;
  logic            sclkPin, chip_select_low, serial_in, serial_out, serialOutEn;
  logic            pen_touch_flag_n, penFlagEn, yMinusGroundEn, xPlusPullupEn, abortSequence;
  logic [3:0]      measure_program_sel;
  logic [2:0]      intervalSelect, filterSelect;
  logic [1:0]      doze_select;
  measure_result_t measureResult;
  int              n_errors = 0;
  int              n_checks = 0;
  int              nAborts  = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (abortSequence) begin
      nAborts <= nAborts + 1;
    end
  end
  touch_controller_host_port dut_u (.clk(clk), .reset_n(reset_n), .sclkPin(sclkPin),
    .chip_select_low(chip_select_low), .serial_in(serial_in), .serial_out(serial_out),
    .serialOutEn(serialOutEn), .xPlusLevel(xPlusLevel), .measureResult(measureResult),
    .resultStrobe(resultStrobe), .sequenceBusy(sequenceBusy), .sequenceValid(sequenceValid),
    .pen_touch_flag_n(pen_touch_flag_n), .penFlagEn(penFlagEn),
    .yMinusGroundEn(yMinusGroundEn), .xPlusPullupEn(xPlusPullupEn),
    .measure_program_sel(measure_program_sel), .intervalSelect(intervalSelect),
    .doze_select(doze_select), .filterSelect(filterSelect), .abortSequence(abortSequence));
  spi_host_model host_u (.clk(clk), .serial_out(serial_out), .serialOutEn(serialOutEn),
    .sclkPin(sclkPin), .chip_select_low(chip_select_low), .serial_in(serial_in));
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
    logic [7:0] r;
    host_u.start_frame(1'b0);
    host_u.shift({1'b0, a}, r);
    foreach (d[i]) begin
      host_u.shift(d[i], r);
      chk(8'hxx, r);
    end
    host_u.end_frame;
  endtask
  task automatic rd(input logic m3, input logic [6:0] a, input logic [7:0] e[$]);
    logic [7:0] r;
    host_u.start_frame(m3);
    host_u.shift({1'b1, a}, r);
    foreach (e[i]) begin
      host_u.shift(8'h00, r);
      chk(e[i], r);
    end
    host_u.end_frame;
  endtask
  task automatic pins(input logic [7:0] exp);
    repeat (6) @(posedge clk);
    chk(exp, {4'h0, pen_touch_flag_n, penFlagEn, yMinusGroundEn, xPlusPullupEn});
  endtask
  initial begin
    reset_n = 1'b0;
    xPlusLevel = 1'b1;
    resultStrobe = 1'b0;
    sequenceBusy = 1'b0;
    sequenceValid = 1'b0;
    measureResult = RESULT_RESET;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    wr(ADDR_RESET, '{8'h01});
    wr(ADDR_SETUP, '{8'h10});
    pins(8'h0C);
    wr(ADDR_SETUP, '{8'h25, 8'hA3});
    chk(8'hA3, {measure_program_sel, 1'b0, intervalSelect});
    chk(8'h25, {2'b00, doze_select, 1'b0, filterSelect});
    pins(8'h08);
    wr(7'h0B, '{8'h11, 8'h22, 8'h33, 8'h44});
    rd(1'b0, 7'h0B, '{8'h11, 8'h22, 8'h00, 8'h00});
    measureResult <= '{12'hABC, 12'h123, 12'h456, 12'h789, 1'b1, 1'b1, 1'b0, 1'b1,
                       1'b1, 10'h155, 8'h5A};
    resultStrobe <= 1'b1;
    @(posedge clk);
    resultStrobe <= 1'b0;
    rd(1'b0, ADDR_STATUS,
       '{8'h6C, 8'hAB, 8'hC0, 8'h12, 8'h30, 8'h45, 8'h60, 8'h78, 8'h90});
    rd(1'b1, ADDR_LAST, '{8'h5A, 8'h00, 8'h25, 8'hA3});
    host_u.noise;
    rd(1'b0, ADDR_SETUP, '{8'h25});
    wr(ADDR_SETUP, '{8'h00});
    xPlusLevel <= 1'b0;
    pins(8'h07);
    sequenceBusy <= 1'b1;
    xPlusLevel <= 1'b1;
    repeat (6) @(posedge clk);
    chk(8'h00, {7'h00, pen_touch_flag_n});
    sequenceBusy <= 1'b0;
    pins(8'h0F);
    wr(ADDR_RESET, '{8'h01});
    chk(8'h00, {measure_program_sel, 2'b00, doze_select});
    rd(1'b0, ADDR_CX_HIGH, '{8'h00});
    rd(1'b0, 7'h0B, '{8'h00});
    chk(8'h02, 8'(nAborts));
    results;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule
`default_nettype wire
